// File: rtl/perf_monitor_params.svh
// Constants of the performance monitor: register numbers, field positions and encodings.
`ifndef PERF_MONITOR_PARAMS_SVH
`define PERF_MONITOR_PARAMS_SVH

// ****************************************************************
// Special register numbers (10-bit)
// ****************************************************************
`define SPR_USER_COUNTER1     10'h3A9
`define SPR_USER_COUNTER2     10'h3AA
`define SPR_USER_SAMPLED_ADDR 10'h3AB
`define SPR_USER_COUNTER3     10'h3AD
`define SPR_USER_COUNTER4     10'h3AE
`define SPR_MONITOR_CONTROL_0 10'h3B8
`define SPR_EVENT_COUNTER1    10'h3B9
`define SPR_EVENT_COUNTER2    10'h3BA
`define SPR_SAMPLED_ADDR      10'h3BB
`define SPR_MONITOR_CONTROL_1 10'h3BC
`define SPR_EVENT_COUNTER3    10'h3BD
`define SPR_EVENT_COUNTER4    10'h3BE

// ****************************************************************
// Field positions, big-endian bit n is little-endian bit 31-n
// ****************************************************************
`define MC0_FREEZE_BIT        31
`define MC0_COND_HI           31
`define MC0_COND_LO           27
`define MC0_COND_SUP_BIT      30
`define MC0_COND_USR_BIT      29
`define MC0_COND_MARK_BIT     28
`define MC0_COND_UNMARK_BIT   27
`define MC0_TB_SEL_HI         24
`define MC0_TB_SEL_LO         23
`define MC0_SEL1_HI           12
`define MC0_SEL1_LO           6
`define MC0_SEL2_HI           5
`define MC0_SEL2_LO           0
`define MC1_SEL3_HI           31
`define MC1_SEL3_LO           27
`define MC1_SEL4_HI           26
`define MC1_SEL4_LO           22
`define MSR_MARKED_BIT        2
`define MSR_USER_BIT          17

// ****************************************************************
// Reference event codes and reset values
// ****************************************************************
`define EV_HOLD               5'h00
`define EV_CYCLES             5'h01
`define EV_COMPLETED          5'h02
`define EV_TIMEBASE           5'h03
`define EV_DISPATCHED         5'h04
`define EV_THRESHOLD          7'h05
`define TB_BIT_SEL0           31
`define TB_BIT_SEL1           23
`define TB_BIT_SEL2           19
`define TB_BIT_SEL3           15
`define RESET_WORD            32'h0000_0000

`endif

// File: rtl/perf_monitor_pkg.sv
// Types of the performance monitor.
package perf_monitor_pkg;

   typedef enum logic [1:0] {
      SAMPLE_IDLE  = 2'b00,
      SAMPLE_ARMED = 2'b01,
      SAMPLE_HELD  = 2'b10
   } sample_state_t;

   typedef struct packed {
      logic [3:0][31:0] event_counters;
      logic [3:0][31:0] user_counter_mirrors;
      logic [31:0]      monitor_control_0;
      logic [31:0]      monitor_control_1;
      logic [31:0]      sampled_instr_addr;
      logic [31:0]      user_sampled_instr_addr;
      logic [31:0]      rd_data;
      logic             rd_valid;
      logic             monitor_irq;
      logic             tb_bit_prev;
      sample_state_t    sample_state;
   } monitor_state_t;

endpackage : perf_monitor_pkg

// File: rtl/perf_monitor_counters.sv
// Performance monitor: four event counters, control registers and sampled address.
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_params.svh"

module perf_monitor_counters #(
   parameter int WIDTH = 32
) (
   input  wire logic              i_clk_sys,
   input  wire logic              i_sys_rst,
   input  wire logic              i_spr_wr,
   input  wire logic              i_spr_rd,
   input  wire logic [9:0]        i_spr_num,
   input  wire logic [WIDTH-1:0]  i_spr_wdata,
   input  wire logic              i_user_mode,
   input  wire logic [WIDTH-1:0]  i_machine_state_reg,
   input  wire logic [WIDTH-1:0]  i_timebase_low,
   input  wire logic [1:0]        i_completed_count,
   input  wire logic [1:0]        i_dispatched_count,
   input  wire logic [WIDTH-1:0]  i_last_completed_addr,
   input  wire logic              i_threshold_event,
   input  wire logic              i_threshold_head_of_queue,
   input  wire logic [WIDTH-1:0]  i_threshold_instr_addr,
   input  wire logic [3:0][1:0]   i_other_event_count,
   output logic [WIDTH-1:0]       o_spr_rdata,
   output logic                   o_spr_rd_valid,
   output logic                   o_monitor_irq,
   output logic [WIDTH-1:0]       o_sampled_instr_addr
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************

   // Supervisor-only numbers read as zero from user mode.
   function automatic logic is_user_visible(input logic [9:0] num);
      is_user_visible = (num == `SPR_USER_COUNTER1) || (num == `SPR_USER_COUNTER2)
                     || (num == `SPR_USER_COUNTER3) || (num == `SPR_USER_COUNTER4)
                     || (num == `SPR_USER_SAMPLED_ADDR);
   endfunction : is_user_visible

   function automatic logic [1:0] counter_index(input logic [9:0] num);
      case (num)
         `SPR_EVENT_COUNTER1, `SPR_USER_COUNTER1: counter_index = 2'd0;
         `SPR_EVENT_COUNTER2, `SPR_USER_COUNTER2: counter_index = 2'd1;
         `SPR_EVENT_COUNTER3, `SPR_USER_COUNTER3: counter_index = 2'd2;
         default:                                 counter_index = 2'd3;
      endcase
   endfunction : counter_index

   function automatic logic is_counter_spr(input logic [9:0] num);
      is_counter_spr = (num == `SPR_EVENT_COUNTER1) || (num == `SPR_EVENT_COUNTER2)
                    || (num == `SPR_EVENT_COUNTER3) || (num == `SPR_EVENT_COUNTER4);
   endfunction : is_counter_spr

   // Reference events are shared; code 5 on counter one is the threshold event.
   function automatic logic [2:0] ref_increment(
      input logic [6:0] code,
      input logic       tb_rise,
      input logic [1:0] other
   );
      case (code)
         {2'b00, `EV_HOLD}:       ref_increment = 3'd0;
         {2'b00, `EV_CYCLES}:     ref_increment = 3'd1;
         {2'b00, `EV_COMPLETED}:  ref_increment = {1'b0, i_completed_count};
         {2'b00, `EV_TIMEBASE}:   ref_increment = {2'b00, tb_rise};
         {2'b00, `EV_DISPATCHED}: ref_increment = {1'b0, i_dispatched_count};
         default:                 ref_increment = {1'b0, other};
      endcase
   endfunction : ref_increment

   // ****************************************************************
   // State
   // ****************************************************************
   perf_monitor_pkg::monitor_state_t st_r;
   perf_monitor_pkg::monitor_state_t st_nxt;

   logic             count_enable;
   logic             tb_bit;
   logic             tb_rise;
   logic [3:0][6:0]  sel;
   logic [3:0]       overflow;
   logic             thr_hit;
   logic [1:0]       idx;

   always_comb begin
      // Marked bit comes from machine state; user flag from the same register.
      logic marked;
      logic user;
      logic [4:0] cond;
      marked = i_machine_state_reg[`MSR_MARKED_BIT];
      user   = i_machine_state_reg[`MSR_USER_BIT];
      cond   = st_r.monitor_control_0[`MC0_COND_HI:`MC0_COND_LO];
      if (cond[4]) begin
         count_enable = 1'b0;
      end else if (cond == 5'h00) begin
         count_enable = 1'b1;
      end else begin
         // Each set bit excludes one state, so combinations give all sixteen modes.
         count_enable = !(st_r.monitor_control_0[`MC0_COND_SUP_BIT] && !user)
                     && !(st_r.monitor_control_0[`MC0_COND_USR_BIT] && user)
                     && !(st_r.monitor_control_0[`MC0_COND_MARK_BIT] && marked)
                     && !(st_r.monitor_control_0[`MC0_COND_UNMARK_BIT] && !marked);
      end
   end

   always_comb begin
      case (st_r.monitor_control_0[`MC0_TB_SEL_HI:`MC0_TB_SEL_LO])
         2'b00:   tb_bit = i_timebase_low[31 - `TB_BIT_SEL0];
         2'b01:   tb_bit = i_timebase_low[31 - `TB_BIT_SEL1];
         2'b10:   tb_bit = i_timebase_low[31 - `TB_BIT_SEL2];
         default: tb_bit = i_timebase_low[31 - `TB_BIT_SEL3];
      endcase
   end

   assign tb_rise = tb_bit && !st_r.tb_bit_prev;
   assign sel[0]  = st_r.monitor_control_0[`MC0_SEL1_HI:`MC0_SEL1_LO];
   assign sel[1]  = {1'b0, st_r.monitor_control_0[`MC0_SEL2_HI:`MC0_SEL2_LO]};
   assign sel[2]  = {2'b00, st_r.monitor_control_1[`MC1_SEL3_HI:`MC1_SEL3_LO]};
   assign sel[3]  = {2'b00, st_r.monitor_control_1[`MC1_SEL4_HI:`MC1_SEL4_LO]};
   // Only head-of-queue accesses qualify; misaligned, multiple and string forms are not
   // filtered, so their threshold counts may be inexact.
   assign thr_hit = (sel[0] == `EV_THRESHOLD) && i_threshold_event
                 && i_threshold_head_of_queue;
   assign idx     = counter_index(i_spr_num);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [WIDTH-1:0] sum;
      logic [2:0]       inc;
      logic             irq;
      st_nxt = st_r;
      sum = '0;
      inc = '0;
      irq = 1'b0;
      st_nxt.tb_bit_prev = tb_bit;
      for (int n = 0; n < 4; n++) begin
         inc = ref_increment(sel[n], tb_rise, i_other_event_count[n]);
         if (n == 0 && sel[0] == `EV_THRESHOLD) begin
            inc = {2'b00, thr_hit};
         end
         sum = st_r.event_counters[n] + {{(WIDTH-3){1'b0}}, inc};
         overflow[n] = sum[WIDTH-1] && !st_r.event_counters[n][WIDTH-1];
         if (count_enable) begin
            st_nxt.event_counters[n] = sum;
         end else begin
            overflow[n] = 1'b0;
         end
      end
      if (i_spr_wr && !i_user_mode) begin
         if (is_counter_spr(i_spr_num)) begin
            st_nxt.event_counters[idx] = i_spr_wdata;
         end
         if (i_spr_num == `SPR_MONITOR_CONTROL_0) begin
            st_nxt.monitor_control_0 = i_spr_wdata;
         end
         if (i_spr_num == `SPR_MONITOR_CONTROL_1) begin
            st_nxt.monitor_control_1 = i_spr_wdata;
         end
      end
      // The interrupt level follows any counter top bit.
      irq = 1'b0;
      for (int n = 0; n < 4; n++) begin
         irq = irq | st_nxt.event_counters[n][WIDTH-1];
      end
      st_nxt.monitor_irq = irq;
      // Sample once when a counter overflows by counting; hold until the interrupt condition falls.
      case (st_r.sample_state)
         perf_monitor_pkg::SAMPLE_IDLE: begin
            if (|overflow) begin
               st_nxt.sample_state = perf_monitor_pkg::SAMPLE_HELD;
               if (overflow[0] && thr_hit) begin
                  st_nxt.sampled_instr_addr = i_threshold_instr_addr;
               end else begin
                  st_nxt.sampled_instr_addr = i_last_completed_addr;
               end
            end
         end
         perf_monitor_pkg::SAMPLE_HELD: begin
            if (!irq) begin
               st_nxt.sample_state = perf_monitor_pkg::SAMPLE_IDLE;
            end
         end
         default: begin
            st_nxt.sample_state = perf_monitor_pkg::SAMPLE_IDLE;
         end
      endcase
      // A software write wins over a same-cycle sample.
      if (i_spr_wr && !i_user_mode && i_spr_num == `SPR_SAMPLED_ADDR) begin
         st_nxt.sampled_instr_addr = i_spr_wdata;
      end
      // Mirrors take the next value, so they change with the source edge.
      st_nxt.user_counter_mirrors    = st_nxt.event_counters;
      st_nxt.user_sampled_instr_addr = st_nxt.sampled_instr_addr;
      // Read port: one-cycle answer the edge after the request.
      st_nxt.rd_valid = i_spr_rd;
      st_nxt.rd_data  = '0;
      if (i_spr_rd && (!i_user_mode || is_user_visible(i_spr_num))) begin
         case (i_spr_num)
            `SPR_USER_COUNTER1, `SPR_USER_COUNTER2,
            `SPR_USER_COUNTER3, `SPR_USER_COUNTER4:
               st_nxt.rd_data = st_r.user_counter_mirrors[idx];
            `SPR_EVENT_COUNTER1, `SPR_EVENT_COUNTER2,
            `SPR_EVENT_COUNTER3, `SPR_EVENT_COUNTER4:
               st_nxt.rd_data = st_r.event_counters[idx];
            `SPR_USER_SAMPLED_ADDR: st_nxt.rd_data = st_r.user_sampled_instr_addr;
            `SPR_SAMPLED_ADDR:      st_nxt.rd_data = st_r.sampled_instr_addr;
            `SPR_MONITOR_CONTROL_0: st_nxt.rd_data = st_r.monitor_control_0;
            `SPR_MONITOR_CONTROL_1: st_nxt.rd_data = st_r.monitor_control_1;
            default:                st_nxt.rd_data = '0;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_spr_rdata          = st_r.rd_data;
   assign o_spr_rd_valid       = st_r.rd_valid;
   assign o_monitor_irq        = st_r.monitor_irq;
   assign o_sampled_instr_addr = st_r.sampled_instr_addr;

endmodule : perf_monitor_counters
`default_nettype wire

// File: verification/core_event_model.sv
// Behavioural model of the core pipeline that feeds events to the monitor.
`timescale 1ns/1ps
`default_nettype none
module core_event_model (
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic [7:0] i_len,
   input  wire logic       i_thresh,
   input  wire logic [1:0] i_state,
   output logic            o_busy,
   output logic [31:0]     o_msr,
   output logic [31:0]     o_tb,
   output logic [1:0]      o_done_cnt,
   output logic [1:0]      o_disp_cnt,
   output logic [31:0]     o_last_addr,
   output logic            o_thr,
   output logic [31:0]     o_thr_addr,
   output logic [3:0][1:0] o_other
);
   logic       go = 1'b0;
   logic [7:0] left = 8'h00;
   logic [7:0] n;
   logic       act;
   initial {o_busy, o_msr, o_tb, o_done_cnt, o_disp_cnt, o_last_addr, o_thr, o_thr_addr,
            o_other} = '0;
   always @(posedge i_clk) go <= i_start;
   // Outputs move on the falling edge so the monitor samples settled values.
   always @(negedge i_clk) begin
      n = go ? i_len : left;
      act = n != 8'h00;
      left <= act ? n - 8'h01 : 8'h00;
      o_busy <= act;
      o_msr <= {14'h0, i_state[1], 14'h0, i_state[0], 2'h0};
      o_tb <= {32{act && !n[0]}};
      o_done_cnt <= act ? 2'h3 : 2'h0;
      o_disp_cnt <= act ? 2'h2 : 2'h0;
      o_other <= act ? {4{2'h1}} : '0;
      // Idle address buses invert each cycle, so a stale value never looks valid.
      o_last_addr <= act ? 32'h1000_0000 + {22'h0, n, 2'h0} : ~o_last_addr;
      o_thr <= act && i_thresh;
      o_thr_addr <= (act && i_thresh) ? 32'h2000_00F0 : ~o_thr_addr;
   end
endmodule : core_event_model
`default_nettype wire

// File: verification/perf_monitor_counters_asserts.sv
// Concurrent checks on the performance monitor ports.
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_params.svh"
module perf_monitor_counters_asserts #(
   parameter int WIDTH = 32
) (
   input wire logic             i_clk_sys,
   input wire logic             i_sys_rst,
   input wire logic             i_spr_wr,
   input wire logic             i_spr_rd,
   input wire logic [9:0]       i_spr_num,
   input wire logic [WIDTH-1:0] i_spr_wdata,
   input wire logic             i_user_mode,
   input wire logic [WIDTH-1:0] o_spr_rdata,
   input wire logic             o_spr_rd_valid,
   input wire logic             o_monitor_irq,
   input wire logic [WIDTH-1:0] o_sampled_instr_addr
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   rd_answer_a: assert property (i_spr_rd |=> o_spr_rd_valid)
      else $error("read not answered after one cycle");
   rd_spurious_a: assert property (!i_spr_rd |=> !o_spr_rd_valid)
      else $error("read valid without a read");
   reset_clear_a: assert property (disable iff (1'b0) i_sys_rst |=>
      !o_spr_rd_valid && !o_monitor_irq && o_sampled_instr_addr == '0)
      else $error("outputs not cleared by reset");
   sia_write_a: assert property (i_spr_wr && !i_user_mode &&
      i_spr_num == `SPR_SAMPLED_ADDR |-> ##[1:2] o_sampled_instr_addr == $past(i_spr_wdata))
      else $error("sampled address write lost");
   sia_mirror_a: assert property (i_spr_rd && i_spr_num == `SPR_USER_SAMPLED_ADDR &&
      $stable(o_sampled_instr_addr) |=> o_spr_rdata == $past(o_sampled_instr_addr))
      else $error("user sampled address differs");
   sia_hidden_a: assert property (i_spr_rd && i_user_mode &&
      i_spr_num == `SPR_SAMPLED_ADDR |=> o_spr_rdata == '0)
      else $error("user read of sampled address not zero");
   irq_top_bit_a: assert property (i_spr_wr && !i_user_mode &&
      i_spr_num == `SPR_EVENT_COUNTER1 && i_spr_wdata[31:30] == 2'b10 ##1 !i_spr_wr
      |-> ##[0:1] o_monitor_irq)
      else $error("top bit set without interrupt");
   sia_held_a: assert property (o_monitor_irq && $past(o_monitor_irq) &&
      $past(o_monitor_irq, 2) && !$past(i_spr_wr) && !$past(i_spr_wr, 2)
      |-> $stable(o_sampled_instr_addr))
      else $error("sampled address moved while held");
endmodule : perf_monitor_counters_asserts
bind perf_monitor_counters perf_monitor_counters_asserts #(.WIDTH(WIDTH)) i_asserts (
   .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_spr_wr(i_spr_wr), .i_spr_rd(i_spr_rd),
   .i_spr_num(i_spr_num), .i_spr_wdata(i_spr_wdata), .i_user_mode(i_user_mode),
   .o_spr_rdata(o_spr_rdata), .o_spr_rd_valid(o_spr_rd_valid),
   .o_monitor_irq(o_monitor_irq), .o_sampled_instr_addr(o_sampled_instr_addr));
`default_nettype wire

// File: verification/perf_monitor_counters_bench.sv
// Self-checking bench for the performance monitor.
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_params.svh"
module perf_monitor_counters_bench;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            wr = 1'b0;
   logic            rd = 1'b0;
   logic            um = 1'b0;
   logic            start = 1'b0;
   logic            thr = 1'b0;
   logic            hq = 1'b1;
   logic [1:0]      st = 2'h0;
   logic [7:0]      len = 8'h00;
   logic [9:0]      num = 10'h000;
   logic [31:0]     wdata = 32'h0;
   logic [31:0]     rdata, machine_state_reg, tb, last, taddr, sampled_instruction_address;
   logic [1:0]      done, disp;
   logic [3:0][1:0] other;
   logic            rv, irq, busy, th, en;
   int              fail_count = 0;
   int              compares = 0;
   int              cyc = 0;
   int              wr_cyc, a, c, i;
   logic [9:0]      cn [4] = '{`SPR_EVENT_COUNTER1, `SPR_EVENT_COUNTER2,
                               `SPR_EVENT_COUNTER3, `SPR_EVENT_COUNTER4};
   logic [9:0]      mn [4] = '{`SPR_USER_COUNTER1, `SPR_USER_COUNTER2,
                               `SPR_USER_COUNTER3, `SPR_USER_COUNTER4};
   perf_monitor_counters i_perf_monitor_counters (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_spr_wr(wr), .i_spr_rd(rd), .i_spr_num(num), .i_spr_wdata(wdata), .i_user_mode(um),
      .i_machine_state_reg(machine_state_reg), .i_timebase_low(tb), .i_completed_count(done),
      .i_dispatched_count(disp), .i_last_completed_addr(last), .i_threshold_event(th),
      .i_threshold_head_of_queue(th && hq), .i_threshold_instr_addr(taddr),
      .i_other_event_count(other), .o_spr_rdata(rdata), .o_spr_rd_valid(rv),
      .o_monitor_irq(irq), .o_sampled_instr_addr(sampled_instruction_address));
   core_event_model i_core_event_model (.i_clk(clk), .i_start(start), .i_len(len),
      .i_thresh(thr), .i_state(st), .o_busy(busy), .o_msr(machine_state_reg), .o_tb(tb),
      .o_done_cnt(done), .o_disp_cnt(disp), .o_last_addr(last), .o_thr(th),
      .o_thr_addr(taddr), .o_other(other));
   initial forever #25 clk = ~clk;
   // ****************************************************************
   // Access tasks and checking
   // ****************************************************************
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // The run is far shorter than this ceiling; reaching it means a hang.
   always @(negedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      compares++;
      if (seen !== ex) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   task automatic wrs(input logic [9:0] n, input logic [31:0] d, input logic u);
      @(negedge clk);
      {wr, num, wdata, um} = {1'b1, n, d, u};
      @(posedge clk);
      wr_cyc = cyc;
      @(negedge clk);
      wr = 1'b0;
   endtask : wrs
   task automatic rdc(input logic [9:0] n, input logic u, input logic [31:0] ex);
      @(negedge clk);
      {rd, num, um} = {1'b1, n, u};
      @(posedge clk);
      @(negedge clk);
      rd = 1'b0;
      chk($sformatf("spr %0d", n), (rv === 1'b1) ? rdata : 32'hDEAD_BEEF, ex);
   endtask : rdc
   task automatic burst(input logic [7:0] n);
      @(negedge clk);
      {start, len} = {1'b1, n};
      @(negedge clk);
      start = 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
   endtask : burst
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 4; i++) rdc(cn[i], 1'b0, 32'h0);
      rdc(`SPR_MONITOR_CONTROL_0, 1'b0, 32'h0);
      rdc(`SPR_MONITOR_CONTROL_1, 1'b0, 32'h0);
      rdc(`SPR_SAMPLED_ADDR, 1'b0, 32'h0);
      for (i = 0; i < 4; i++) begin
         wrs(cn[i], 32'h0000_0100 + i, 1'b0);
         wrs(cn[i], 32'h0, 1'b1);
         wrs(mn[i], 32'h0, 1'b0);
         rdc(cn[i], 1'b0, 32'h0000_0100 + i);
         rdc(mn[i], 1'b1, 32'h0000_0100 + i);
         rdc(cn[i], 1'b1, 32'h0);
      end
      wrs(`SPR_SAMPLED_ADDR, 32'h0000_0ABC, 1'b0);
      wrs(`SPR_USER_SAMPLED_ADDR, 32'h0, 1'b0);
      wrs(`SPR_SAMPLED_ADDR, 32'h0, 1'b1);
      rdc(`SPR_SAMPLED_ADDR, 1'b0, 32'h0000_0ABC);
      rdc(`SPR_USER_SAMPLED_ADDR, 1'b1, 32'h0000_0ABC);
      wrs(`SPR_MONITOR_CONTROL_0, 32'h8000_0000, 1'b0);
      wrs(`SPR_MONITOR_CONTROL_1, 32'h08C0_0000, 1'b0);
      // Every exclusion pattern against every privilege and mark state and timebase tap.
      for (c = 0; c < 256; c++) begin
         st <= c[5:4];
         en = !(c[3] && !c[5]) && !(c[2] && c[5]) && !(c[1] && c[4]) && !(c[0] && !c[4]);
         for (i = 0; i < 4; i++) wrs(cn[i], 32'h0000_0010, 1'b0);
         wrs(`SPR_MONITOR_CONTROL_0, {1'b0, c[3:0], 2'b0, c[7:6], 10'h0, 7'h04, 6'h02}, 1'b0);
         a = wr_cyc;
         burst(8'h06);
         wrs(`SPR_MONITOR_CONTROL_0, 32'h8000_0000, 1'b0);
         rdc(cn[0], 1'b0, en ? 32'h0000_001C : 32'h0000_0010);
         rdc(cn[1], 1'b0, en ? 32'h0000_0022 : 32'h0000_0010);
         rdc(cn[2], 1'b0, 32'h0000_0010 + (en ? wr_cyc - a : 0));
         rdc(cn[3], 1'b0, en ? 32'h0000_0013 : 32'h0000_0010);
      end
      burst(8'h04);
      rdc(cn[2], 1'b0, 32'h0000_0010);
      wrs(cn[0], 32'h7FFF_FFFF, 1'b0);
      wrs(`SPR_MONITOR_CONTROL_0, 32'h0000_0140, 1'b0);
      // A threshold access away from the queue head must not count.
      hq <= 1'b0;
      thr <= 1'b1;
      burst(8'h01);
      rdc(cn[0], 1'b0, 32'h7FFF_FFFF);
      hq <= 1'b1;
      burst(8'h01);
      thr <= 1'b0;
      chk("irq", {31'h0, irq}, 32'h1);
      rdc(`SPR_SAMPLED_ADDR, 1'b0, 32'h2000_00F0);
      chk("sia", sampled_instruction_address, 32'h2000_00F0);
      wrs(`SPR_MONITOR_CONTROL_0, 32'h8000_0000, 1'b0);
      wrs(cn[0], 32'h0, 1'b0);
      wrs(cn[1], 32'h7FFF_FFFE, 1'b0);
      chk("irq", {31'h0, irq}, 32'h0);
      // A software write of the top bit raises the interrupt but takes no sample.
      wrs(cn[0], 32'h8000_0000, 1'b0);
      chk("irq", {31'h0, irq}, 32'h1);
      chk("sia", sampled_instruction_address, 32'h2000_00F0);
      wrs(cn[0], 32'h0, 1'b0);
      chk("irq", {31'h0, irq}, 32'h0);
      wrs(`SPR_MONITOR_CONTROL_0, 32'h0000_0002, 1'b0);
      burst(8'h01);
      rdc(`SPR_SAMPLED_ADDR, 1'b0, 32'h1000_0004);
      rdc(mn[1], 1'b1, 32'h8000_0001);
      rdc(`SPR_SAMPLED_ADDR, 1'b1, 32'h0);
      rdc(10'h100, 1'b0, 32'h0);
      summarize();
   end
endmodule : perf_monitor_counters_bench
`default_nettype wire
